// ### core/cspr_pkg.sv
/*
 * Constants shared by the core status and pointer registers.
 * Assumes an 8-bit special register space at 0x80..0xff.
 */
package cspr_pkg;

    // Byte addresses of the registers held here
    localparam logic [7:0] STK_PTR_ADDR = 8'h81;
    localparam logic [7:0] PTR_LOW_ADDR = 8'h82;
    localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hd0;
    localparam logic [7:0] ARITH_MAIN_ADDR = 8'he0;

    // Values after reset
    localparam logic [7:0] STK_PTR_RESET = 8'h07;
    localparam logic [7:0] PTR_LOW_RESET = 8'h00;
    localparam logic [7:0] PTR_HIGH_RESET = 8'h00;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam logic [7:0] ARITH_MAIN_RESET = 8'h00;

    // Status word bit positions
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER_FLAG_ZERO_BIT = 5;
    localparam int BANK_SELECT_HIGH_BIT = 4;
    localparam int BANK_SELECT_LOW_BIT = 3;
    localparam int OVERFLOW_BIT = 2;
    localparam int USER_FLAG_ONE_BIT = 1;
    localparam int PARITY_BIT = 0;

    // Register bank geometry: eight registers per bank
    localparam int BANK_SHIFT = 3;

    // Lowest special register address
    localparam logic [7:0] SPECIAL_BASE = 8'h80;

    // Arithmetic operations presented by the core
    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_SUM_WITH_CARRY = 3'h1,
        OP_SUB_BORROW = 3'h2,
        OP_PRODUCT = 3'h3,
        OP_DIVIDE = 3'h4
    } cspr_op_t;

    // Stack store sequencer, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WRITE = 2'b10
    } cspr_state_t;

endpackage

// ### core/cspr_arith_unit.sv
/*
 * Combinational arithmetic and flag generation for the core.
 * Assumes operands are stable for the cycle in which they are used.
 */
`timescale 1ns/1ps

module cspr_arith_unit
    import cspr_pkg::*;
(
    // Operation and operands
    input wire cspr_op_t op,
    input wire logic [7:0] opa,
    input wire logic [7:0] opb,
    input wire logic carry_in,
    // Results and flags
    output logic [7:0] res_low,
    output logic [7:0] res_high,
    output logic carry_out,
    output logic half_out,
    output logic overflow_out
);

    logic cin;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [8:0] sub9;
    logic [4:0] sub5;
    logic [15:0] prod;
    logic div_zero;
    logic [7:0] quot;
    logic [7:0] rem;

    // Carry only enters the carry-using operations
    assign cin = (op == OP_SUM_WITH_CARRY || op == OP_SUB_BORROW)
        ? carry_in : 1'b0;
    assign sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    assign sum5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    assign sub9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    assign sub5 = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
    assign prod = {8'h00, opa} * {8'h00, opb};
    assign div_zero = (opb == 8'h00);
    // Divisor zero would be undefined; keep the dividend
    assign quot = div_zero ? opa : opa / opb;
    assign rem = div_zero ? 8'h00 : opa % opb;

    // Result and flag selection per operation
    always_comb
    begin
        res_low = sum9[7:0];
        res_high = 8'h00;
        carry_out = 1'b0;
        half_out = 1'b0;
        overflow_out = 1'b0;
        case (op)
            OP_ADD, OP_SUM_WITH_CARRY:
            begin
                carry_out = sum9[8];
                half_out = sum5[4];
                overflow_out = (opa[7] == opb[7]) &&
                    (sum9[7] != opa[7]);
            end
            OP_SUB_BORROW:
            begin
                res_low = sub9[7:0];
                carry_out = sub9[8];
                half_out = sub5[4];
                overflow_out = (opa[7] != opb[7]) &&
                    (sub9[7] != opa[7]);
            end
            OP_PRODUCT:
            begin
                res_low = prod[7:0];
                res_high = prod[15:8];
                overflow_out = (prod[15:8] != 8'h00);
            end
            OP_DIVIDE:
            begin
                res_low = quot;
                res_high = rem;
                overflow_out = div_zero;
            end
            default:
            begin
                res_low = opa;
            end
        endcase
    end

endmodule

// ### core/cspr_core_regs.sv
/*
 * Core status and pointer registers: stack top, indirect pointer,
 * main arithmetic register and status word, with byte access to all four and
 * bit access to the last two on the special register ports, and a small stack store sequencer.
 * Assumes the core drives all requests synchronous to clk and holds
 * the external stack memory itself.
 */
`timescale 1ns/1ps

module cspr_core_regs
    import cspr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Byte access port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Bit access port
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_rd,
    input wire logic bit_wdata,
    output logic bit_rdata,
    output logic bit_hit,
    // Arithmetic request
    input wire logic arith_valid,
    input wire cspr_op_t arith_op,
    input wire logic [7:0] arith_operand,
    output logic [7:0] arith_high,
    // Stack store and remove
    input wire logic push_req,
    input wire logic [7:0] push_data,
    output logic push_ready,
    input wire logic pop_req,
    output logic stack_wr_en,
    output logic [7:0] stack_wr_addr,
    output logic [7:0] stack_wr_data,
    // Views used by the rest of the core
    output logic [15:0] indirect_pointer,
    output logic [7:0] stack_top_pointer,
    output logic [7:0] bank_base,
    output logic [7:0] program_status_word,
    output logic [7:0] arith_main_register
);

    // Registers
    logic [7:0] arith_main_q;
    logic [7:0] arith_main_d;
    logic [7:0] ptr_low_q;
    logic [7:0] ptr_low_d;
    logic [7:0] ptr_high_q;
    logic [7:0] ptr_high_d;
    logic [7:0] stk_q;
    logic [7:0] stk_d;
    logic carry_flag_q;
    logic carry_flag_d;
    logic half_carry_flag_q;
    logic half_carry_flag_d;
    logic user_flag_zero_q;
    logic user_flag_zero_d;
    logic [1:0] bank_q;
    logic [1:0] bank_d;
    logic overflow_flag_q;
    logic overflow_flag_d;
    logic user_flag_one_q;
    logic user_flag_one_d;
    logic [7:0] sfr_rdata_q;
    logic bit_rdata_q;
    logic [7:0] arith_high_q;
    logic [7:0] push_data_q;
    cspr_state_t state_q;
    cspr_state_t state_d;

    // Arithmetic unit outputs
    logic [7:0] alu_low;
    logic [7:0] alu_high;
    logic alu_carry;
    logic alu_half;
    logic alu_overflow;

    // Decode and write path wires
    logic parity_now;
    logic [7:0] status_now;
    logic [7:0] bit_byte_addr;
    logic [2:0] bit_index;
    logic bit_legal;
    logic [7:0] bit_byte_now;
    logic [7:0] bit_byte_new;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_main;
    logic wr_low;
    logic wr_high;
    logic wr_stk;
    logic wr_status;
    logic push_start;
    logic carry_op;

    // Reads of an address: zero for anything this block does not own
    function automatic logic [7:0] read_reg(
        input logic [7:0] addr,
        input logic [7:0] main_v,
        input logic [7:0] low_v,
        input logic [7:0] high_v,
        input logic [7:0] stk_v,
        input logic [7:0] status_v
    );
        logic [7:0] r;
        r = 8'h00;
        if (addr == ARITH_MAIN_ADDR)
            r = main_v;
        else if (addr == STATUS_WORD_ADDR)
            r = status_v;
        else if (addr == PTR_LOW_ADDR)
            r = low_v;
        else if (addr == PTR_HIGH_ADDR)
            r = high_v;
        else if (addr == STK_PTR_ADDR)
            r = stk_v;
        return r;
    endfunction

    // Ownership of an address by this block
    function automatic logic owns(input logic [7:0] addr);
        return addr == ARITH_MAIN_ADDR || addr == STATUS_WORD_ADDR ||
            addr == PTR_LOW_ADDR || addr == PTR_HIGH_ADDR ||
            addr == STK_PTR_ADDR;
    endfunction

    // Bit access needs a byte address whose low nibble is 0x0 or 0x8
    function automatic logic bit_capable(input logic [7:0] addr);
        return addr[2:0] == 3'h0;
    endfunction

    // Arithmetic unit
    cspr_arith_unit u_arith (
        .op(arith_op),
        .opa(arith_main_q),
        .opb(arith_operand),
        .carry_in(carry_flag_q),
        .res_low(alu_low),
        .res_high(alu_high),
        .carry_out(alu_carry),
        .half_out(alu_half),
        .overflow_out(alu_overflow)
    );

    // Parity is never stored, so it cannot lag the register
    assign parity_now = ^arith_main_q;
    assign status_now = {carry_flag_q, half_carry_flag_q, user_flag_zero_q,
        bank_q, overflow_flag_q, user_flag_one_q, parity_now};

    // Bit address splits into byte and bit index
    assign bit_byte_addr = {bit_addr[7:3], 3'h0};
    assign bit_index = bit_addr[2:0];
    // Bits below 0x80 are core RAM bits, not handled here
    assign bit_legal = bit_addr[7] && bit_capable(bit_byte_addr) &&
        owns(bit_byte_addr);
    assign bit_byte_now = read_reg(bit_byte_addr, arith_main_q, ptr_low_q,
        ptr_high_q, stk_q, status_now);
    assign bit_byte_new = bit_wdata
        ? (bit_byte_now | (8'h01 << bit_index))
        : (bit_byte_now & ~(8'h01 << bit_index));

    // Byte writes win over a bit write in the same cycle
    assign wr_en = sfr_wr || (bit_wr && bit_legal);
    assign wr_addr = sfr_wr ? sfr_addr : bit_byte_addr;
    assign wr_data = sfr_wr ? sfr_wdata : bit_byte_new;

    // Write decode; reserved addresses fall through unmatched
    assign wr_main = wr_en && wr_addr == ARITH_MAIN_ADDR;
    assign wr_status = wr_en && wr_addr == STATUS_WORD_ADDR;
    assign wr_low = wr_en && wr_addr == PTR_LOW_ADDR;
    assign wr_high = wr_en && wr_addr == PTR_HIGH_ADDR;
    assign wr_stk = wr_en && wr_addr == STK_PTR_ADDR;

    // Carry flag takes the unit's carry only on add, add with carry and subtract
    assign carry_op = arith_op == OP_ADD ||
        arith_op == OP_SUM_WITH_CARRY || arith_op == OP_SUB_BORROW;

    // Main register: software write beats an arithmetic result
    always_comb
    begin
        arith_main_d = arith_main_q;
        if (wr_main)
            arith_main_d = wr_data;
        else if (arith_valid)
            arith_main_d = alu_low;
    end

    // Status word flags; bit 0 is never written
    always_comb
    begin
        carry_flag_d = carry_flag_q;
        half_carry_flag_d = half_carry_flag_q;
        overflow_flag_d = overflow_flag_q;
        user_flag_zero_d = user_flag_zero_q;
        user_flag_one_d = user_flag_one_q;
        bank_d = bank_q;
        if (wr_status)
        begin
            carry_flag_d = wr_data[CARRY_BIT];
            half_carry_flag_d = wr_data[HALF_CARRY_BIT];
            user_flag_zero_d = wr_data[USER_FLAG_ZERO_BIT];
            bank_d = {wr_data[BANK_SELECT_HIGH_BIT],
                wr_data[BANK_SELECT_LOW_BIT]};
            overflow_flag_d = wr_data[OVERFLOW_BIT];
            user_flag_one_d = wr_data[USER_FLAG_ONE_BIT];
        end
        else if (arith_valid)
        begin
            // Product and divide clear carry; half carry holds
            carry_flag_d = carry_op ? alu_carry : 1'b0;
            if (carry_op)
                half_carry_flag_d = alu_half;
            overflow_flag_d = alu_overflow;
        end
    end

    // Pointer bytes take software writes only
    assign ptr_low_d = wr_low ? wr_data : ptr_low_q;
    assign ptr_high_d = wr_high ? wr_data : ptr_high_q;

    // A store is only started while the sequencer is idle
    assign push_start = push_req && (state_q == ST_IDLE);
    assign push_ready = (state_q == ST_IDLE);

    // Stack top: store and remove beat a software write
    always_comb
    begin
        stk_d = stk_q;
        if (push_start)
            stk_d = stk_q + 8'h01;
        else if (pop_req && state_q == ST_IDLE)
            stk_d = stk_q - 8'h01;
        else if (wr_stk)
            stk_d = wr_data;
    end

    // Store sequencer: raise the top, then write at the new top
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (push_start)
                    state_d = ST_WRITE;
            end
            ST_WRITE:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Register state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arith_main_q <= ARITH_MAIN_RESET;
            ptr_low_q <= PTR_LOW_RESET;
            ptr_high_q <= PTR_HIGH_RESET;
            stk_q <= STK_PTR_RESET;
            {carry_flag_q, half_carry_flag_q, user_flag_zero_q, bank_q,
                overflow_flag_q, user_flag_one_q} <=
                STATUS_WORD_RESET[7:1];
            state_q <= ST_IDLE;
        end
        else
        begin
            arith_main_q <= arith_main_d;
            ptr_low_q <= ptr_low_d;
            ptr_high_q <= ptr_high_d;
            stk_q <= stk_d;
            carry_flag_q <= carry_flag_d;
            half_carry_flag_q <= half_carry_flag_d;
            user_flag_zero_q <= user_flag_zero_d;
            bank_q <= bank_d;
            overflow_flag_q <= overflow_flag_d;
            user_flag_one_q <= user_flag_one_d;
            state_q <= state_d;
        end
    end

    // Read data and side results are held in flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sfr_rdata_q <= 8'h00;
            bit_rdata_q <= 1'b0;
            arith_high_q <= 8'h00;
            push_data_q <= 8'h00;
        end
        else
        begin
            if (sfr_rd)
                sfr_rdata_q <= read_reg(sfr_addr, arith_main_q, ptr_low_q,
                    ptr_high_q, stk_q, status_now);
            if (bit_rd)
                bit_rdata_q <= bit_legal && bit_byte_now[bit_index];
            if (arith_valid)
                arith_high_q <= alu_high;
            if (push_start)
                push_data_q <= push_data;
        end
    end

    // Address hits, for the core's own read multiplexer
    assign sfr_hit = owns(sfr_addr);
    assign bit_hit = bit_legal;

    // Store port: write lands at the already raised top
    assign stack_wr_en = (state_q == ST_WRITE);
    assign stack_wr_addr = stk_q;
    assign stack_wr_data = push_data_q;

    // Views
    assign sfr_rdata = sfr_rdata_q;
    assign bit_rdata = bit_rdata_q;
    assign arith_high = arith_high_q;
    assign indirect_pointer = {ptr_high_q, ptr_low_q};
    assign stack_top_pointer = stk_q;
    assign bank_base = {3'h0, bank_q, 3'h0};
    assign program_status_word = status_now;
    assign arith_main_register = arith_main_q;

endmodule

// ### testbench/cspr_core_regs_asserts.sv
/* Checker for the core status and pointer registers.
   Assumes it is bound to cspr_core_regs and sees only its ports. */
`timescale 1ns/1ps
module cspr_core_regs_asserts
    import cspr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Access ports
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_hit,
    // Arithmetic and stack
    input wire logic arith_valid,
    input wire cspr_op_t arith_op,
    input wire logic [7:0] arith_operand,
    input wire logic push_req,
    input wire logic push_ready,
    input wire logic stack_wr_en,
    input wire logic [7:0] stack_wr_addr,
    // Register views
    input wire logic [15:0] indirect_pointer,
    input wire logic [7:0] stack_top_pointer,
    input wire logic [7:0] bank_base,
    input wire logic [7:0] program_status_word,
    input wire logic [7:0] arith_main_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Software writes win, so only lone ops count
    wire arith_go = arith_valid && !sfr_wr && !bit_wr;
    wire [8:0] add_sum = {1'b0, arith_main_register} + {1'b0, arith_operand};
    wire [4:0] add_half = {1'b0, arith_main_register[3:0]} +
        {1'b0, arith_operand[3:0]};

    ptr_join_a: assert property (sfr_wr && sfr_addr == PTR_HIGH_ADDR
        |=> indirect_pointer == {$past(sfr_wdata), $past(indirect_pointer[7:0])})
        else $error("pointer join");
    push_first_a: assert property (push_req && push_ready
        |=> stack_wr_en && stack_wr_addr == $past(stack_top_pointer) + 8'h01
        && stack_top_pointer == stack_wr_addr) else $error("bad store");
    wr_pulse_a: assert property (stack_wr_en |=> !stack_wr_en && push_ready)
        else $error("strobe length");
    reset_value_a: assert property ($rose(rst_n) |->
        stack_top_pointer == STK_PTR_RESET && program_status_word == 8'h00
        && arith_main_register == 8'h00 && indirect_pointer == 16'h0000)
        else $error("bad reset value");
    parity_follow_a: assert property (program_status_word[PARITY_BIT] ==
        ^arith_main_register) else $error("parity wrong");
    bank_map_a: assert property (bank_base ==
        {3'h0, program_status_word[4:3], 3'h0}) else $error("bank wrong");
    reserved_read_a: assert property (sfr_rd && !(sfr_addr inside
        {8'h81, 8'h82, 8'h83, 8'hd0, 8'he0}) |=> sfr_rdata == 8'h00)
        else $error("reserved read");
    bit_only_a: assert property (bit_hit == (bit_addr[7:3] == 5'h1a ||
        bit_addr[7:3] == 5'h1c)) else $error("bit decode wrong");
    prod_ovf_a: assert property (arith_go && arith_op == OP_PRODUCT
        |=> program_status_word[OVERFLOW_BIT] == ($past(arith_main_register)
        * $past(arith_operand) > 16'h00ff)) else $error("product overflow");
    div_zero_a: assert property (arith_go && arith_op == OP_DIVIDE
        && arith_operand == 8'h00 |=> program_status_word[OVERFLOW_BIT]
        && $stable(arith_main_register)) else $error("divide by zero");
    add_carry_a: assert property (arith_go && arith_op == OP_ADD
        |=> program_status_word[CARRY_BIT] == $past(add_sum[8]) &&
        program_status_word[HALF_CARRY_BIT] == $past(add_half[4]))
        else $error("add carry wrong");
    add_ovf_a: assert property (arith_go && arith_op == OP_ADD
        |=> program_status_word[OVERFLOW_BIT] == $past(add_sum[7] !=
        arith_main_register[7] && arith_operand[7] == arith_main_register[7]))
        else $error("add overflow wrong");
endmodule

// ### testbench/cspr_core_regs_tb.sv
/* Self-checking bench for the core status and pointer registers.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
module cspr_core_regs_tb
    import cspr_pkg::*;
;
    // Stimulus and design outputs
    logic clk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata;
    logic arith_valid, push_req, pop_req;
    logic [7:0] sfr_addr, sfr_wdata, bit_addr, arith_operand, push_data;
    cspr_op_t arith_op;
    logic sfr_hit, bit_rdata, bit_hit, push_ready, stack_wr_en;
    logic [7:0] sfr_rdata, arith_high, stack_wr_addr, stack_wr_data;
    logic [7:0] stack_top_pointer, bank_base, program_status_word;
    logic [7:0] arith_main_register;
    logic [15:0] indirect_pointer;
    // Reference model
    logic [7:0] m_top, m_main, m_high, m_flags;
    logic [15:0] m_ptr;
    int fail_count = 0, checked = 0;
    logic [7:0] addrs [11] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'h97,
        8'hae, 8'haf, 8'hb4, 8'hbf, 8'hf5};
    logic [19:0] corners [9] = '{20'h07f01, 20'h0ff01, 20'h10f00,
        20'h28001, 20'h20000, 20'h3ffff, 20'h30f11, 20'h45500, 20'h4ff10};

    cspr_core_regs dut (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .sfr_hit, .bit_addr, .bit_wr, .bit_rd,
        .bit_wdata, .bit_rdata, .bit_hit, .arith_valid, .arith_op,
        .arith_operand, .arith_high, .push_req, .push_data, .push_ready,
        .pop_req, .stack_wr_en, .stack_wr_addr, .stack_wr_data,
        .indirect_pointer, .stack_top_pointer, .bank_base,
        .program_status_word, .arith_main_register);

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Expected values
    function automatic logic [7:0] exp_psw();
        return {m_flags[7:1], ^m_main};
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            STK_PTR_ADDR: return m_top;
            PTR_LOW_ADDR: return m_ptr[7:0];
            PTR_HIGH_ADDR: return m_ptr[15:8];
            STATUS_WORD_ADDR: return exp_psw();
            ARITH_MAIN_ADDR: return m_main;
            default: return 8'h00;
        endcase
    endfunction
    // Flags, main and high byte after one op
    function automatic logic [23:0] exp_arith(input cspr_op_t op,
        input logic [7:0] a, input logic [7:0] b);
        logic [7:0] f;
        logic [8:0] s;
        logic [4:0] h;
        logic [15:0] p;
        logic c;
        f = m_flags;
        c = (op == OP_ADD) ? 1'b0 : f[7];
        f[7] = 1'b0;
        case (op)
            OP_PRODUCT:
            begin
                p = {8'h00, a} * {8'h00, b};
                f[2] = p > 16'h00ff;
                return {f, p[7:0], p[15:8]};
            end
            OP_DIVIDE:
            begin
                f[2] = b == 8'h00;
                return f[2] ? {f, a, 8'h00} : {f, a / b, a % b};
            end
            OP_SUB_BORROW:
            begin
                s = {1'b0, a} - {1'b0, b} - {8'h00, c};
                h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
                f[2] = (a[7] != b[7]) && (s[7] != a[7]);
            end
            default:
            begin
                s = {1'b0, a} + {1'b0, b} + {8'h00, c};
                h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
                f[2] = (a[7] == b[7]) && (s[7] != a[7]);
            end
        endcase
        f[7] = s[8];
        f[6] = h[4];
        return {f, s[7:0], 8'h00};
    endfunction

    // Comparison, reporting and verdict
    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                exp);
        end
    endtask
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask
    task automatic finish_test();
        $display("checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check_views();
        check8(indirect_pointer[7:0], m_ptr[7:0], "ptr low");
        check8(indirect_pointer[15:8], m_ptr[15:8], "ptr high");
        check8(stack_top_pointer, m_top, "top");
        check8(program_status_word, exp_psw(), "psw");
        check8(bank_base, {3'h0, m_flags[4:3], 3'h0}, "bank");
        check8(arith_main_register, m_main, "main");
    endtask

    // Reset, then model
    task automatic reset_dut(input int cycles);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        {m_top, m_main, m_high, m_flags, m_ptr} = {STK_PTR_RESET, 40'h0};
    endtask
    // One byte port strobe
    task automatic byte_op(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        byte_op(1'b1, a, d);
        case (a)
            STK_PTR_ADDR: m_top = d;
            PTR_LOW_ADDR: m_ptr[7:0] = d;
            PTR_HIGH_ADDR: m_ptr[15:8] = d;
            STATUS_WORD_ADDR: m_flags = {d[7:1], 1'b0};
            ARITH_MAIN_ADDR: m_main = d;
            default: ;
        endcase
        check_views();
    endtask
    task automatic rd(input logic [7:0] a);
        byte_op(1'b0, a, 8'h00);
        check8(sfr_rdata, exp_rd(a), "byte read");
        check8({7'h00, sfr_hit}, {7'h00, a[3:0] < 4'h4}, "hit");
    endtask
    // Bit access; parity, unowned bits ignore writes
    task automatic bit_op(input logic w, input logic [7:0] a, input logic v);
        logic [7:0] e = (a[7:3] == 5'h1a) ? exp_psw() :
            (a[7:3] == 5'h1c) ? m_main : 8'h00;
        @(posedge clk);
        bit_wr <= w;
        bit_rd <= !w;
        bit_addr <= a;
        bit_wdata <= v;
        @(posedge clk);
        bit_wr <= 1'b0;
        bit_rd <= 1'b0;
        #1;
        if (!w)
            check8({7'h00, bit_rdata}, {7'h00, e[a[2:0]]}, "bit");
        else if (a[7:3] == 5'h1a && a[2:0] != 3'h0)
            m_flags[a[2:0]] = v;
        else if (a[7:3] == 5'h1c)
            m_main[a[2:0]] = v;
    endtask
    task automatic arith(input cspr_op_t op, input logic [7:0] b);
        logic [23:0] r = exp_arith(op, m_main, b);
        @(posedge clk);
        arith_valid <= 1'b1;
        arith_op <= op;
        arith_operand <= b;
        @(posedge clk);
        arith_valid <= 1'b0;
        #1;
        {m_flags, m_main, m_high} = r;
        check_views();
        check8(arith_high, m_high, "high");
    endtask
    // Store or remove after a bounded wait
    task automatic stack_op(input logic up, input logic [7:0] d);
        int n = 0;
        while (push_ready !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 8)
        begin
            fail_count++;
            finish_test();
        end
        @(posedge clk);
        push_req <= up;
        pop_req <= !up;
        push_data <= d;
        @(posedge clk);
        push_req <= 1'b0;
        pop_req <= 1'b0;
        #1;
        m_top = up ? m_top + 8'h01 : m_top - 8'h01;
        check_views();
        if (up)
        begin
            check8({7'h00, stack_wr_en}, 8'h01, "strobe");
            check8(stack_wr_addr, m_top, "store address");
            check8(stack_wr_data, d, "store data");
        end
    endtask

    // Main sequence
    initial
    begin
        logic [7:0] a;
        {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, arith_valid} = 6'h00;
        {push_req, pop_req, rst_n} = 3'h0;
        {sfr_addr, sfr_wdata, bit_addr, arith_operand, push_data} = 40'h0;
        arith_op = OP_ADD;
        void'($urandom(33971));
        reset_dut(8);
        check_views();
        foreach (addrs[i]) rd(addrs[i]);
        end_test("reset values");
        for (int i = 0; i < 4; i++)
        begin
            wr(STATUS_WORD_ADDR, {3'h5, 2'(i), 3'h3});
            rd(STATUS_WORD_ADDR);
        end
        repeat (60)
        begin
            a = addrs[$urandom_range(10, 0)];
            wr(a, a[3:0] < 4'h4 ? 8'($urandom) : 8'h00);
            rd(addrs[$urandom_range(10, 0)]);
        end
        end_test("byte access");
        repeat (60)
        begin
            a = ($urandom_range(1, 0) == 0) ? 8'($urandom) :
                {$urandom_range(1, 0) ? 5'h1a : 5'h1c, 3'($urandom)};
            bit_op(1'b1, a, 1'($urandom));
            bit_op(1'b0, a, 1'b0);
            check_views();
        end
        end_test("bit access");
        foreach (corners[i])
        begin
            wr(ARITH_MAIN_ADDR, corners[i][15:8]);
            arith(cspr_op_t'(corners[i][18:16]), corners[i][7:0]);
        end
        repeat (150)
        begin
            if ($urandom_range(1, 0) == 1)
                wr(ARITH_MAIN_ADDR, 8'($urandom));
            a = ($urandom_range(7, 0) == 0) ? 8'h00 : 8'($urandom);
            arith(cspr_op_t'($urandom_range(4, 0)), a);
        end
        end_test("arithmetic");
        wr(STK_PTR_ADDR, 8'hfe);
        repeat (3) stack_op(1'b1, 8'($urandom));
        repeat (2) stack_op(1'b0, 8'h00);
        repeat (20) stack_op(1'($urandom), 8'($urandom));
        end_test("stack");
        reset_dut(2);
        check_views();
        foreach (addrs[i]) rd(addrs[i]);
        end_test("second reset");
        finish_test();
    end
endmodule

bind cspr_core_regs cspr_core_regs_asserts chk (.*);
